// *** mct_pkg.sv ***
// Constants, field layout and shared helpers of the five-channel timer control block.
// Assumes one 100 MHz clock and byte-wide registers on a plain strobe port.
// Operation
// [RL1] Run bit per channel gates counting
// [RL2] Unsynchronised channel presets and clears alone
// [RL3] Synchronised channels preset and clear together
// [RL4] Phase bit puts channel 2 in phase count
// [RL5] Direction 0: flag on overflow or underflow
// [RL6] Direction 1: flag on overflow only
// [RL7] Per-channel pulse mode select bits 4..0
// [RL8] All control bits reset to zero
// [RL9] Combination field selects channel 3/4 mode
// [RL10] Buffer bits pair channel 3/4 registers
// [RL11] Writes act next cycle; fixed bits constant
package mct_pkg;

  // Widths
  localparam int NUM_CH = 5;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 28;
  localparam int DATA_W = 8;

  // Register addresses
  localparam logic [27:0] RUN_OFS = 28'h5ffff00;
  localparam logic [27:0] SYNC_OFS = 28'h5ffff01;
  localparam logic [27:0] MODE_OFS = 28'h5ffff02;
  localparam logic [27:0] FUNC_OFS = 28'h5ffff03;
  localparam logic [27:0] STATUS_OFS = 28'h5ffff40;
  localparam logic [27:0] MASK_OFS = 28'h5ffff41;

  // Field positions
  localparam int PHASE_BIT = 6;
  localparam int FLAG_DIRECTION_BIT = 5;
  localparam int CMB_HI_BIT = 5;
  localparam int CMB_LO_BIT = 4;
  localparam int BUF_B4_BIT = 3;
  localparam int BUF_A4_BIT = 2;
  localparam int BUF_B3_BIT = 1;
  localparam int BUF_A3_BIT = 0;
  localparam int WRAP_CH = 2;

  // Writable bits, the fixed value of the others, reset values and the counter maximum
  localparam logic [7:0] RUN_WMASK = 8'h1f;
  localparam logic [7:0] RUN_FIXED = 8'he0;
  localparam logic [7:0] SYNC_WMASK = 8'h1f;
  localparam logic [7:0] SYNC_FIXED = 8'he0;
  localparam logic [7:0] MODE_WMASK = 8'h7f;
  localparam logic [7:0] MODE_FIXED = 8'h80;
  localparam logic [7:0] FUNC_WMASK = 8'h3f;
  localparam logic [7:0] FUNC_FIXED = 8'hc0;
  localparam logic [4:0] EVT_MASK_RST = 5'h00;
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [1:0] PHASE_RST = 2'h0;

  // Channel 3/4 combination modes
  typedef enum logic [1:0] {CMB_NORMAL, CMB_COMPLEMENTARY, CMB_RESYNC} mct_combine_type;

  // Written byte merged with the fixed bits
  function automatic logic [7:0] mct_fold(input logic [7:0] wval, input logic [7:0] wmask,
                                          input logic [7:0] fixed);
    return (wval & wmask) | (fixed & ~wmask);
  endfunction : mct_fold

  // Spread a preset or clear on a synchronised channel over every synchronised channel
  function automatic logic [4:0] mct_spread(input logic [4:0] req, input logic [4:0] sync);
    return ((req & sync) != 5'h00) ? (req | sync) : req;
  endfunction : mct_spread

endpackage : mct_pkg

// *** mct_phase_decoder.sv ***
// Two-phase encoder input decoder for the phase counting channel.
// Assumes the phase pins are asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module mct_phase_decoder
  import mct_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Encoder pins
  input wire logic phase_a_pin,
  input wire logic phase_b_pin,
  // Step pulses
  output logic step_up,
  output logic step_down
);

  logic [1:0] meta_q, meta_d;
  logic [1:0] sync_q, sync_d;
  logic [1:0] prev_q, prev_d;
  logic up_q, up_d;
  logic down_q, down_d;
  logic one_edge;

  // Two stages before any logic, third keeps the previous sample
  always_comb begin
    meta_d = {phase_a_pin, phase_b_pin};
    sync_d = meta_q;
    prev_d = sync_q;
    // A double change is a lost step; counting it either way would be a guess
    one_edge = (sync_q[1] ^ prev_q[1]) ^ (sync_q[0] ^ prev_q[0]);
    up_d = one_edge & (prev_q[1] ^ sync_q[0]);
    down_d = one_edge & ~(prev_q[1] ^ sync_q[0]);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_q <= PHASE_RST;
      sync_q <= PHASE_RST;
      prev_q <= PHASE_RST;
      up_q <= 1'b0;
      down_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
      up_q <= up_d;
      down_q <= down_d;
    end
  end

  assign step_up = up_q;
  assign step_down = down_q;

endmodule : mct_phase_decoder
`default_nettype wire

// *** mct_channel_counter.sv ***
// One 16-bit channel counter with clear, preset and up/down stepping.
// Assumes step requests come from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module mct_channel_counter
  import mct_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Control
  input wire logic count_up,
  input wire logic count_down,
  input wire logic load,
  input wire logic clear,
  input wire logic [15:0] load_value,
  // State
  output logic [15:0] count,
  output logic overflow,
  output logic underflow
);

  logic [15:0] cnt_q, cnt_d;
  logic ovf_q, ovf_d;
  logic udf_q, udf_d;

  // Clear beats preset beats stepping
  always_comb begin
    cnt_d = cnt_q;
    ovf_d = 1'b0;
    udf_d = 1'b0;
    if (clear) begin
      cnt_d = CNT_RST;
    end else if (load) begin
      cnt_d = load_value;
    end else if (count_up) begin // RL1
      cnt_d = cnt_q + 16'h0001;
      ovf_d = (cnt_q == CNT_MAX);
    end else if (count_down) begin
      cnt_d = cnt_q - 16'h0001;
      udf_d = (cnt_q == CNT_RST);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= CNT_RST;
      ovf_q <= 1'b0;
      udf_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
      udf_q <= udf_d;
    end
  end

  assign count = cnt_q;
  assign overflow = ovf_q;
  assign underflow = udf_q;

endmodule : mct_channel_counter
`default_nettype wire

// *** mct_timer_ctrl.sv ***
// Shared control of the five-channel timer: run, synchronisation, mode and
// combination registers, the channel counters and the wrap interrupt.
// Assumes a same-clock register master and asynchronous encoder pins.
`timescale 1ns/1ps
`default_nettype none
module mct_timer_ctrl
  import mct_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic [27:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Channel requests from prescaler and compare logic
  input wire logic [4:0] count_tick,
  input wire logic [4:0] clear_req,
  input wire logic [4:0] preset_req,
  input wire logic [15:0] preset_value,
  // Encoder pins for channel 2
  input wire logic phase_a_pin,
  input wire logic phase_b_pin,
  // Counter values
  output logic [15:0] counter_ch0,
  output logic [15:0] counter_ch1,
  output logic [15:0] counter_ch2,
  output logic [15:0] counter_ch3,
  output logic [15:0] counter_ch4,
  // Per-channel controls
  output logic [4:0] run_ch,
  output logic [4:0] syncsel_ch,
  output logic [4:0] pulse_mode_ch,
  // Channel 2 mode
  output logic phase_count_select,
  output logic flag_direction,
  // Channel 3/4 combination and buffering
  output logic combine_mode_hi,
  output logic combine_mode_lo,
  output logic complementary_pwm,
  output logic reset_sync_pwm,
  output logic buffer_b_ch4,
  output logic buffer_a_ch4,
  output logic buffer_b_ch3,
  output logic buffer_a_ch3,
  // Events
  output logic wrap_flag,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] run_q, run_d;
  logic [7:0] sync_q, sync_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] func_q, func_d;
  logic [4:0] status_q, status_d;
  logic [4:0] mask_q, mask_d;
  logic irq_q, irq_d;
  logic [7:0] rdata_q, rdata_d;
  mct_combine_type combine_q, combine_d;
  logic cpwm_q, cpwm_d;
  logic rpwm_q, rpwm_d;

  // Decoded write strobes, one per register
  logic wr_run, wr_sync, wr_mode, wr_func, wr_status, wr_mask;
  logic [4:0] status_clr;
  logic [4:0] wrap_set;
  // Per-channel requests after the sync fan-out and run gating
  logic [4:0] clear_all;
  logic [4:0] preset_all;
  logic [4:0] step_up;
  logic [4:0] step_down;
  // Counter events and values
  logic [4:0] ovf;
  logic [4:0] udf;
  logic [15:0] cnt [NUM_CH];
  // Encoder steps for channel 2
  logic ph_up;
  logic ph_down;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  // Writes land on the next edge and steer the counters from then on
  always_comb begin
    // An unmapped address matches nothing and the write is dropped
    wr_run = reg_wr && (reg_addr == RUN_OFS);
    wr_sync = reg_wr && (reg_addr == SYNC_OFS);
    wr_mode = reg_wr && (reg_addr == MODE_OFS);
    wr_func = reg_wr && (reg_addr == FUNC_OFS);
    wr_status = reg_wr && (reg_addr == STATUS_OFS);
    wr_mask = reg_wr && (reg_addr == MASK_OFS);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  // Next values; unimplemented bits keep their fixed pattern on every write
  always_comb begin
    run_d = run_q;
    sync_d = sync_q;
    mode_d = mode_q;
    func_d = func_q;
    combine_d = combine_q;
    if (wr_run) begin
      run_d = mct_fold(reg_wdata, RUN_WMASK, RUN_FIXED); // RL11
    end
    if (wr_sync) begin
      sync_d = mct_fold(reg_wdata, SYNC_WMASK, SYNC_FIXED); // RL11
    end
    if (wr_mode) begin
      mode_d = mct_fold(reg_wdata, MODE_WMASK, MODE_FIXED); // RL11
    end
    if (wr_func) begin
      func_d = mct_fold(reg_wdata, FUNC_WMASK, FUNC_FIXED); // RL11
      // Both 00 and 01 mean plain operation
      case ({reg_wdata[CMB_HI_BIT], reg_wdata[CMB_LO_BIT]})
        2'h2: begin
          combine_d = CMB_COMPLEMENTARY; // RL9
        end
        2'h3: begin
          combine_d = CMB_RESYNC; // RL9
        end
        default: begin
          combine_d = CMB_NORMAL; // RL9
        end
      endcase
    end
    // Decoded mode flops keep the channel 3/4 selects glitch free
    cpwm_d = (combine_d == CMB_COMPLEMENTARY);
    rpwm_d = (combine_d == CMB_RESYNC);
  end

  // Everything stopped, independent and plain after reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      run_q <= RUN_FIXED; // RL8
      sync_q <= SYNC_FIXED; // RL8
      mode_q <= MODE_FIXED; // RL8
      // Combination field and buffer bits start at plain operation
      func_q <= FUNC_FIXED;
      combine_q <= CMB_NORMAL;
      cpwm_q <= 1'b0;
      rpwm_q <= 1'b0;
    end else begin
      run_q <= run_d;
      sync_q <= sync_d;
      mode_q <= mode_d;
      func_q <= func_d;
      combine_q <= combine_d;
      cpwm_q <= cpwm_d;
      rpwm_q <= rpwm_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter steering

  // Channel 2 encoder decode
  // Pins are synchronised inside, so they may change at any time
  mct_phase_decoder u_phase (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .phase_a_pin(phase_a_pin),
    .phase_b_pin(phase_b_pin),
    .step_up(ph_up),
    .step_down(ph_down)
  );

  // A synchronised request fans out to every synchronised channel
  always_comb begin
    clear_all = mct_spread(clear_req, sync_q[4:0]); // RL2 RL3
    preset_all = mct_spread(preset_req, sync_q[4:0]); // RL2 RL3
    step_up = count_tick & run_q[4:0]; // RL1
    step_down = 5'h00;
    // In phase count the encoder replaces the prescaler tick
    // A stopped channel 2 drops encoder steps; none are queued
    if (mode_q[PHASE_BIT]) begin
      step_up[WRAP_CH] = run_q[WRAP_CH] & ph_up; // RL4
      step_down[WRAP_CH] = run_q[WRAP_CH] & ph_down; // RL4
    end
  end

  // One counter per channel
  // One shared preset value; different presets need separate cycles
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    mct_channel_counter u_cnt (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .count_up(step_up[ch]),
      .count_down(step_down[ch]),
      .load(preset_all[ch]),
      .clear(clear_all[ch]),
      .load_value(preset_value),
      .count(cnt[ch]),
      .overflow(ovf[ch]),
      .underflow(udf[ch])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wrap status and interrupt

  // Only channel 2 can count down, so only it watches the direction bit
  always_comb begin
    wrap_set = ovf;
    wrap_set[WRAP_CH] = ovf[WRAP_CH] | (udf[WRAP_CH] & ~mode_q[FLAG_DIRECTION_BIT]); // RL5 RL6
    // Write one to clear; a zero leaves the bit alone
    status_clr = wr_status ? reg_wdata[4:0] : 5'h00;
    // A new event beats a clear in the same cycle
    status_d = (status_q & ~status_clr) | wrap_set;
    // Mask bits are plain read/write
    mask_d = wr_mask ? reg_wdata[4:0] : mask_q;
    // Built from next values so the interrupt rises with the flag
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      status_q <= STATUS_RST;
      mask_q <= EVT_MASK_RST;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Data valid only in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_d = RDATA_RST;
    // Reads have no side effect, so software may poll freely
    if (reg_rd) begin
      case (reg_addr)
        RUN_OFS: begin
          rdata_d = run_q;
        end
        SYNC_OFS: begin
          rdata_d = sync_q;
        end
        MODE_OFS: begin
          rdata_d = mode_q;
        end
        FUNC_OFS: begin
          rdata_d = func_q;
        end
        STATUS_OFS: begin
          rdata_d = {3'h0, status_q};
        end
        MASK_OFS: begin
          rdata_d = {3'h0, mask_q};
        end
        default: begin
          rdata_d = RDATA_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= RDATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop

  assign reg_rdata = rdata_q;
  assign counter_ch0 = cnt[0];
  assign counter_ch1 = cnt[1];
  assign counter_ch2 = cnt[2];
  assign counter_ch3 = cnt[3];
  assign counter_ch4 = cnt[4];
  assign run_ch = run_q[4:0];
  assign syncsel_ch = sync_q[4:0];
  assign pulse_mode_ch = mode_q[4:0]; // RL7
  assign phase_count_select = mode_q[PHASE_BIT];
  assign flag_direction = mode_q[FLAG_DIRECTION_BIT];
  assign combine_mode_hi = func_q[CMB_HI_BIT];
  assign combine_mode_lo = func_q[CMB_LO_BIT];
  assign complementary_pwm = cpwm_q;
  assign reset_sync_pwm = rpwm_q;
  // Buffer pairing is carried out in the channel 3/4 compare logic
  assign buffer_b_ch4 = func_q[BUF_B4_BIT]; // RL10
  assign buffer_a_ch4 = func_q[BUF_A4_BIT]; // RL10
  assign buffer_b_ch3 = func_q[BUF_B3_BIT]; // RL10
  assign buffer_a_ch3 = func_q[BUF_A3_BIT]; // RL10
  // Only channel 2's wrap bit leaves the block on its own
  assign wrap_flag = status_q[WRAP_CH];
  assign irq = irq_q;

endmodule : mct_timer_ctrl
`default_nettype wire

// *** mct_timer_ctrl_asserts.sv ***
// Concurrent checks on the ports of the timer control block.
// Assumes it is bound to mct_timer_ctrl, which has one clock domain.
`timescale 1ns/1ps
`default_nettype none
module mct_timer_ctrl_asserts
  import mct_pkg::*;
(
  // Clock, reset and register port
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [27:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Channel requests and counters
  input wire logic [4:0] count_tick,
  input wire logic [4:0] clear_req,
  input wire logic [4:0] preset_req,
  input wire logic [15:0] counter_ch0,
  input wire logic [15:0] counter_ch1,
  input wire logic [15:0] counter_ch2,
  // Control outputs
  input wire logic [4:0] run_ch,
  input wire logic [4:0] syncsel_ch,
  input wire logic [4:0] pulse_mode_ch,
  input wire logic phase_count_select,
  input wire logic flag_direction,
  input wire logic combine_mode_hi,
  input wire logic combine_mode_lo,
  input wire logic complementary_pwm,
  input wire logic reset_sync_pwm,
  input wire logic buffer_b_ch4,
  input wire logic buffer_a_ch4,
  input wire logic buffer_b_ch3,
  input wire logic buffer_a_ch3,
  input wire logic wrap_flag
);
  // Single domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  // Writes land on the outputs one cycle later; combination selects follow the field
  a_run_write: assert property (
    reg_wr && reg_addr == RUN_OFS |=> run_ch == $past(reg_wdata[4:0]))
    else $error("run bits did not follow the write");
  a_sync_write: assert property (
    reg_wr && reg_addr == SYNC_OFS |=> syncsel_ch == $past(reg_wdata[4:0]))
    else $error("sync bits did not follow the write");
  a_mode_write: assert property (
    reg_wr && reg_addr == MODE_OFS |=>
    {phase_count_select, flag_direction, pulse_mode_ch} == $past(reg_wdata[6:0]))
    else $error("mode bits did not follow the write");
  a_func_write: assert property (
    reg_wr && reg_addr == FUNC_OFS |=> {combine_mode_hi, combine_mode_lo, buffer_b_ch4,
    buffer_a_ch4, buffer_b_ch3, buffer_a_ch3} == $past(reg_wdata[5:0]))
    else $error("combination bits did not follow the write");
  a_combine_decode: assert property (
    complementary_pwm == (combine_mode_hi && !combine_mode_lo) &&
    reset_sync_pwm == (combine_mode_hi && combine_mode_lo))
    else $error("combination mode decode wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Counting, clears, the wrap flag and idle read data
  a_stopped_hold: assert property (
    !run_ch[0] && clear_req == 5'h00 && preset_req == 5'h00 |=> $stable(counter_ch0))
    else $error("stopped counter moved");
  a_tick_count: assert property (
    run_ch[1] && count_tick[1] && clear_req == 5'h00 && preset_req == 5'h00 |=>
    counter_ch1 == $past(counter_ch1) + 16'h0001)
    else $error("running counter did not step");
  a_indep_clear: assert property (
    clear_req == 5'h01 && !syncsel_ch[0] && preset_req == 5'h00 && !run_ch[1] |=>
    $stable(counter_ch1))
    else $error("independent clear reached another channel");
  a_sync_clear: assert property (
    clear_req[3] && syncsel_ch[3] && syncsel_ch[1] |=> counter_ch1 == 16'h0000)
    else $error("synchronised clear missed a channel");
  a_wrap_set: assert property (
    run_ch[2] && count_tick[2] && !phase_count_select && counter_ch2 == 16'hffff &&
    clear_req == 5'h00 && preset_req == 5'h00 |=> ##1 wrap_flag)
    else $error("overflow did not set the wrap flag");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside the read cycle");
endmodule : mct_timer_ctrl_asserts

bind mct_timer_ctrl mct_timer_ctrl_asserts chk_u (.clk_sys(clk_sys), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .count_tick(count_tick), .clear_req(clear_req),
  .preset_req(preset_req), .counter_ch0(counter_ch0), .counter_ch1(counter_ch1),
  .counter_ch2(counter_ch2), .run_ch(run_ch), .syncsel_ch(syncsel_ch),
  .pulse_mode_ch(pulse_mode_ch), .phase_count_select(phase_count_select),
  .flag_direction(flag_direction), .combine_mode_hi(combine_mode_hi),
  .combine_mode_lo(combine_mode_lo), .complementary_pwm(complementary_pwm),
  .reset_sync_pwm(reset_sync_pwm), .buffer_b_ch4(buffer_b_ch4),
  .buffer_a_ch4(buffer_a_ch4), .buffer_b_ch3(buffer_b_ch3),
  .buffer_a_ch3(buffer_a_ch3), .wrap_flag(wrap_flag));
`default_nettype wire

// *** test_mct_timer_ctrl.sv ***
// Self-checking bench for the timer control block.
// Assumes the package, design and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_mct_timer_ctrl import mct_pkg::*;;
  logic clk_sys, nrst, reg_wr, reg_rd, phase_a_pin, phase_b_pin, rd_d;
  logic [27:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [4:0] count_tick, clear_req, preset_req;
  logic [15:0] preset_value;
  logic [15:0] ev [5];
  logic [7:0] exp_q [$];
  logic [31:0] rng = 32'hec594336;
  int bad_count = 0;
  int cmp_count = 0;
  wire logic [7:0] reg_rdata;
  wire logic [15:0] counter_ch0, counter_ch1, counter_ch2, counter_ch3, counter_ch4;
  wire logic [4:0] run_ch, syncsel_ch, pulse_mode_ch;
  wire logic phase_count_select, flag_direction, combine_mode_hi, combine_mode_lo;
  wire logic complementary_pwm, reset_sync_pwm, wrap_flag, irq;
  wire logic buffer_b_ch4, buffer_a_ch4, buffer_b_ch3, buffer_a_ch3;
  wire logic [79:0] cnt_all;
  assign cnt_all = {counter_ch4, counter_ch3, counter_ch2, counter_ch1, counter_ch0};

  mct_timer_ctrl dut_u (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .count_tick(count_tick), .clear_req(clear_req), .preset_req(preset_req),
    .preset_value(preset_value), .phase_a_pin(phase_a_pin), .phase_b_pin(phase_b_pin),
    .counter_ch0(counter_ch0), .counter_ch1(counter_ch1), .counter_ch2(counter_ch2),
    .counter_ch3(counter_ch3), .counter_ch4(counter_ch4), .run_ch(run_ch),
    .syncsel_ch(syncsel_ch), .pulse_mode_ch(pulse_mode_ch),
    .phase_count_select(phase_count_select), .flag_direction(flag_direction),
    .combine_mode_hi(combine_mode_hi), .combine_mode_lo(combine_mode_lo),
    .complementary_pwm(complementary_pwm), .reset_sync_pwm(reset_sync_pwm),
    .buffer_b_ch4(buffer_b_ch4), .buffer_a_ch4(buffer_a_ch4), .buffer_b_ch3(buffer_b_ch3),
    .buffer_a_ch3(buffer_a_ch3), .wrap_flag(wrap_flag), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Fixed-seed xorshift keeps runs repeatable
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // Bus cycles leave a gap edge so no strobe is assigned twice in a step
  task automatic wr(input logic [27:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [27:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd

  // Request pulses held n edges, then one settling edge
  task automatic req(input logic [4:0] clr, input logic [4:0] pre, input logic [4:0] tck,
                     input int n);
    @(posedge clk_sys);
    clear_req <= clr;
    preset_req <= pre;
    count_tick <= tck;
    repeat (n) @(posedge clk_sys);
    clear_req <= 5'h00;
    preset_req <= 5'h00;
    count_tick <= 5'h00;
    @(posedge clk_sys);
    #1;
  endtask : req

  task automatic cmp_all();
    for (int i = 0; i < 5; i++) check(cnt_all[i*16 +: 16], ev[i]);
  endtask : cmp_all

  ////////////////////////////////////////////////////////////////////////////
  // Read data checker: stands only in the cycle after the strobe
  always @(posedge clk_sys) rd_d <= reg_rd;
  always @(negedge clk_sys) begin
    if (rd_d === 1'b1) begin
      check({8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
    end
  end

  // Watchdog well beyond the few hundred cycles of the sequence
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    stop_test();
  end

  // Main sequence
  initial begin
    {nrst, reg_wr, reg_rd, phase_a_pin, phase_b_pin} = 5'h00;
    {reg_addr, reg_wdata, count_tick, clear_req, preset_req, preset_value} = '0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(RUN_OFS, 8'he0);
    rd(SYNC_OFS, 8'he0);
    rd(MODE_OFS, 8'h80);
    rd(FUNC_OFS, 8'hc0);
    rd(STATUS_OFS, 8'h00);
    rd(MASK_OFS, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(FUNC_OFS, {2'b00, c[1:0], 4'h0});
      check({complementary_pwm, reset_sync_pwm}, {c == 2, c == 3});
    end
    for (int k = 0; k < 8; k++) begin
      rng = xs(rng);
      wr(RUN_OFS, rng[7:0]);
      wr(SYNC_OFS, rng[15:8]);
      wr(MODE_OFS, rng[23:16]);
      check({phase_count_select, flag_direction, pulse_mode_ch}, rng[22:16]);
      wr(FUNC_OFS, rng[31:24]);
      rd(RUN_OFS, (rng[7:0] & 8'h1f) | 8'he0);
      rd(SYNC_OFS, (rng[15:8] & 8'h1f) | 8'he0);
      rd(MODE_OFS, (rng[23:16] & 8'h7f) | 8'h80);
      rd(FUNC_OFS, (rng[31:24] & 8'h3f) | 8'hc0);
    end
    wr(28'h5ffff10, 8'hff);
    rd(28'h5ffff10, 8'h00);
    check(run_ch, rng[4:0]);
    wr(MODE_OFS, 8'h00);
    wr(SYNC_OFS, 8'h00);
    req(5'h1f, 5'h00, 5'h00, 1);
    rng = xs(rng);
    wr(RUN_OFS, {3'h0, rng[4:0] | 5'h02});
    req(5'h00, 5'h00, 5'h1f, 5);
    for (int i = 0; i < 5; i++) ev[i] = (rng[i] || i == 1) ? 16'h0005 : 16'h0000;
    cmp_all();
    wr(RUN_OFS, 8'h00);
    wr(SYNC_OFS, 8'h0a);
    req(5'h01, 5'h00, 5'h1f, 1);
    ev[0] = 16'h0000;
    cmp_all();
    preset_value <= 16'h1234;
    req(5'h00, 5'h02, 5'h00, 1);
    ev[1] = 16'h1234;
    ev[3] = 16'h1234;
    cmp_all();
    req(5'h08, 5'h00, 5'h00, 1);
    ev[1] = 16'h0000;
    ev[3] = 16'h0000;
    cmp_all();
    wr(SYNC_OFS, 8'h00);
    preset_value <= 16'hffff;
    req(5'h00, 5'h04, 5'h00, 1);
    wr(RUN_OFS, 8'h04);
    req(5'h00, 5'h00, 5'h04, 1);
    check(counter_ch2, 16'h0000);
    check(wrap_flag, 1'b1);
    wr(MASK_OFS, 8'h04);
    @(posedge clk_sys);
    #1;
    check(irq, 1'b1);
    wr(MASK_OFS, 8'h00);
    @(posedge clk_sys);
    #1;
    check(irq, 1'b0);
    rd(STATUS_OFS, 8'h04);
    wr(STATUS_OFS, 8'h04);
    check(wrap_flag, 1'b0);
    wr(MODE_OFS, 8'h60);
    req(5'h04, 5'h00, 5'h00, 1);
    @(posedge clk_sys);
    phase_a_pin <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    check(counter_ch2, 16'hffff);
    check(wrap_flag, 1'b0);
    wr(MODE_OFS, 8'h40);
    req(5'h04, 5'h00, 5'h00, 1);
    @(posedge clk_sys);
    phase_b_pin <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    check(counter_ch2, 16'hffff);
    check(wrap_flag, 1'b1);
    wr(STATUS_OFS, 8'h04);
    wr(MODE_OFS, 8'h60);
    @(posedge clk_sys);
    phase_b_pin <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    check(counter_ch2, 16'h0000);
    check(wrap_flag, 1'b1);
    repeat (3) @(posedge clk_sys);
    stop_test();
  end
endmodule : test_mct_timer_ctrl
`default_nettype wire
